// file: design/ssf_flash_device.sv
// Serial NOR flash device behind an SPI slave port (mode 0 or 3).
// Assumes the host drives chip select, serial clock and data slower than
// a quarter of i_clk; all pins are synchronised before use.
// Overview of operation
// - Lock bit 7 set makes the three protect bits unwritable.
// - Status bits 6 and 5 always read zero.
// - Bits 4 to 2 hold the three block-protect bits.
// - Bit 1 shows the write-enable latch.
// - Bit 0 shows a program or erase cycle in progress.
// - Status read returns exactly one byte after the opcode.
// - Each frame starts with one opcode byte.
// - Read, program and sector erase carry three address bytes.
// - Program page is 256 bytes.
// - Array holds 2097152 bytes; higher addresses are refused.
// - Identification read returns three bytes.
// - Power-down release returns a one-byte signature.
// - Opcodes 0x03 and 0x0b read the array.
// - Opcode 0x02 programs the array.
// - Opcode 0xd8 erases a sector, 0xc7 the whole array.
// - Opcode 0xb9 sleeps, 0xab wakes and returns the signature.
`timescale 1ns/10ps
`include "ssf_regs.svh"
module ssf_flash_device #(
    parameter int unsigned STORE_AW = 10,
    parameter int unsigned PROG_CYCLES = `SSF_PROG_CYCLES,
    parameter int unsigned SERASE_CYCLES = `SSF_SERASE_CYCLES,
    parameter int unsigned BERASE_CYCLES = `SSF_BERASE_CYCLES,
    parameter logic [7:0] MAKER_ID = 8'hA5,  // Arbitrary value
    parameter logic [7:0] TYPE_ID = 8'h5A,   // Arbitrary value
    parameter logic [7:0] CAP_ID = 8'h15,    // Arbitrary value
    parameter logic [7:0] SIGNATURE = 8'h3C  // Arbitrary value
) (
    input wire logic i_clk,
    input wire logic i_srst,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_host_data_output,
    output logic o_host_data_input,
    output logic o_host_data_input_oe,
    output ssf_pkg::ssf_status_type o_flash_status
);
    localparam int unsigned STORE_BYTES = 1 << STORE_AW;

    logic [1:0] cs_sync_q, sclk_sync_q, mosi_sync_q;
    logic cs_prev_q, sclk_prev_q;
    logic cs_n, sclk_rise, sclk_fall, cs_rise, byte_done;
    logic [2:0] bit_cnt_q, byte_cnt_q, nxt_idx;
    logic [6:0] rx_sh_q;
    logic [7:0] rx_byte, opcode_q, op_now, tx_next, tx_q, tx_sh_q;
    logic tx_en, tx_en_q, rd_take;
    logic [23:0] addr_q, rd_q, cur_rd;
    logic [7:0] page_q [`SSF_PAGE_SIZE];
    logic [`SSF_PAGE_SIZE-1:0] pmask_q;
    logic [7:0] pg_ptr_q;
    logic [7:0] mem_q [STORE_BYTES];
    ssf_pkg::ssf_status_type status_q;
    ssf_pkg::ssf_op_type op_q;
    logic [31:0] busy_cnt_q;
    logic accept, do_prog, do_serase, do_berase, do_wrsr;

    // Pins cross into i_clk; only the second stage is read
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            cs_sync_q <= 2'h3;
            sclk_sync_q <= 2'h3;
            mosi_sync_q <= 2'h3;
            cs_prev_q <= 1'b1;
            sclk_prev_q <= 1'b1;
        end else begin
            cs_sync_q <= {cs_sync_q[0], i_cs_n};
            sclk_sync_q <= {sclk_sync_q[0], i_sclk};
            mosi_sync_q <= {mosi_sync_q[0], i_host_data_output};
            cs_prev_q <= cs_sync_q[1];
            sclk_prev_q <= sclk_sync_q[1];
        end
    end

    // Edges of the serial clock count only inside a frame
    assign cs_n = cs_sync_q[1];
    assign cs_rise = cs_n & ~cs_prev_q;
    assign sclk_rise = ~cs_n & sclk_sync_q[1] & ~sclk_prev_q;
    assign sclk_fall = ~cs_n & ~sclk_sync_q[1] & sclk_prev_q;
    assign byte_done = sclk_rise & (bit_cnt_q == 3'h7);
    assign rx_byte = {rx_sh_q, mosi_sync_q[1]};
    assign nxt_idx = (byte_cnt_q == 3'h7) ? 3'h7 : byte_cnt_q + 3'h1;

    // Receive shifter and byte counter, cleared while deselected
    always_ff @(posedge i_clk) begin
        if (i_srst || cs_n) begin
            bit_cnt_q <= 3'h0;
            byte_cnt_q <= 3'h0;
            rx_sh_q <= 7'h00;
        end else if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            rx_sh_q <= rx_byte[6:0];
            if (bit_cnt_q == 3'h7) begin
                byte_cnt_q <= nxt_idx;
            end
        end
    end

    // Opcode, address and read pointer capture
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            opcode_q <= 8'h00;
            addr_q <= 24'h000000;
            rd_q <= 24'h000000;
        end else if (byte_done) begin
            if (byte_cnt_q == 3'h0) begin
                opcode_q <= rx_byte;
            end
            if (byte_cnt_q >= `SSF_CMD_SIZE && byte_cnt_q <= `SSF_ADDR_SIZE) begin
                addr_q <= {addr_q[15:0], rx_byte};
            end
            if (byte_cnt_q >= `SSF_ADDR_SIZE) begin
                rd_q <= cur_rd + {23'h000000, rd_take};
            end
        end
    end

    // Next byte to return, chosen at each byte boundary
    always_comb begin
        op_now = (byte_cnt_q == 3'h0) ? rx_byte : opcode_q;
        cur_rd = (byte_cnt_q == 3'h3) ? {addr_q[15:0], rx_byte} : rd_q;
        tx_next = 8'h00;
        tx_en = 1'b0;
        rd_take = 1'b0;
        if (op_q == ssf_pkg::SSF_SLEEP) begin
            if (op_now == `SSF_OP_RES && nxt_idx == 3'h1) begin
                tx_next = SIGNATURE;
                tx_en = 1'b1;
            end
        end else if (op_now == `SSF_OP_RDSR) begin
            if (nxt_idx == 3'h1) begin
                tx_next = status_q;
                tx_en = 1'b1;
            end
        end else if (op_q == ssf_pkg::SSF_IDLE) begin
            case (op_now)
                `SSF_OP_RDID: begin
                    tx_en = (nxt_idx <= 3'h3);
                    tx_next = (nxt_idx == 3'h1) ? MAKER_ID :
                              (nxt_idx == 3'h2) ? TYPE_ID :
                              (nxt_idx == 3'h3) ? CAP_ID : 8'h00;
                end
                `SSF_OP_RES: begin
                    tx_en = (nxt_idx == 3'h1);
                    tx_next = tx_en ? SIGNATURE : 8'h00;
                end
                `SSF_OP_READ, `SSF_OP_FAST: begin
                    // Fast read keeps one dummy byte after the address
                    rd_take = (op_now == `SSF_OP_READ) ? (nxt_idx >= 3'h4)
                                                       : (nxt_idx >= 3'h5);
                    tx_en = rd_take;
                    if (rd_take) begin
                        tx_next = (cur_rd < `SSF_MEM_SIZE) ?
                                  mem_q[cur_rd[STORE_AW-1:0]] : 8'hFF;
                    end
                end
                default: begin
                    tx_next = 8'h00;
                end
            endcase
        end
    end

    // Return data changes on falling serial clock edges
    always_ff @(posedge i_clk) begin
        if (i_srst || cs_n) begin
            tx_q <= 8'h00;
            tx_en_q <= 1'b0;
            tx_sh_q <= 8'h00;
            o_host_data_input <= 1'b0;
            o_host_data_input_oe <= 1'b0;
        end else begin
            if (byte_done) begin
                tx_q <= tx_next;
                tx_en_q <= tx_en;
            end
            if (sclk_fall) begin
                if (bit_cnt_q == 3'h0) begin
                    o_host_data_input <= tx_q[7];
                    o_host_data_input_oe <= tx_en_q;
                    tx_sh_q <= {tx_q[6:0], 1'b0};
                end else begin
                    o_host_data_input <= tx_sh_q[7];
                    tx_sh_q <= {tx_sh_q[6:0], 1'b0};
                end
            end
        end
    end

    // Top fraction of the array guarded by the protect field
    function automatic logic prot_hit(input logic [23:0] a, input logic [2:0] bp);
        logic [23:0] span;
        span = `SSF_MEM_SIZE >> (3'h7 - bp);
        return (bp != 3'h0) && (a >= `SSF_MEM_SIZE - span);
    endfunction

    // Frame-end decisions; a frame must close on a byte boundary
    assign accept = cs_rise && (op_q == ssf_pkg::SSF_IDLE) && (bit_cnt_q == 3'h0);
    assign do_wrsr = accept && opcode_q == `SSF_OP_WRSR && byte_cnt_q == 3'h2
                     && status_q.write_enable_latch;
    assign do_prog = accept && opcode_q == `SSF_OP_PROG && byte_cnt_q >= 3'h5
                     && status_q.write_enable_latch && addr_q < `SSF_MEM_SIZE
                     && !prot_hit(addr_q, status_q.bp);
    assign do_serase = accept && opcode_q == `SSF_OP_SERASE && byte_cnt_q == 3'h4
                       && status_q.write_enable_latch && addr_q < `SSF_MEM_SIZE
                       && !prot_hit(addr_q & `SSF_SECTOR_MASK, status_q.bp);
    assign do_berase = accept && opcode_q == `SSF_OP_BERASE && byte_cnt_q == 3'h1
                       && status_q.write_enable_latch && status_q.bp == 3'h0;

    // Status register and busy sequencing
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            status_q <= `SSF_ST_RESET;
            op_q <= ssf_pkg::SSF_IDLE;
            busy_cnt_q <= 32'h0;
        end else begin
            status_q.rsvd <= 2'h0;
            case (op_q)
                ssf_pkg::SSF_IDLE: begin
                    if (do_prog) begin
                        op_q <= ssf_pkg::SSF_PROG;
                        busy_cnt_q <= PROG_CYCLES;
                        status_q.busy <= 1'b1;
                    end else if (do_serase || do_berase) begin
                        op_q <= ssf_pkg::SSF_ERASE;
                        busy_cnt_q <= do_berase ? BERASE_CYCLES : SERASE_CYCLES;
                        status_q.busy <= 1'b1;
                    end else if (do_wrsr) begin
                        // Protect field frozen while the lock bit is set
                        // Data byte is the last one shifted into the address
                        if (!status_q.lock) begin
                            status_q.bp <= addr_q[`SSF_ST_BP_HI:`SSF_ST_BP_LO];
                        end
                        status_q.lock <= addr_q[`SSF_ST_LOCK];
                        status_q.write_enable_latch <= 1'b0;
                    end else if (accept && byte_cnt_q == 3'h1) begin
                        if (opcode_q == `SSF_OP_WREN) begin
                            status_q.write_enable_latch <= 1'b1;
                        end else if (opcode_q == `SSF_OP_WRDI) begin
                            status_q.write_enable_latch <= 1'b0;
                        end else if (opcode_q == `SSF_OP_DPD) begin
                            op_q <= ssf_pkg::SSF_SLEEP;
                        end
                    end
                end
                ssf_pkg::SSF_PROG, ssf_pkg::SSF_ERASE: begin
                    if (busy_cnt_q <= 32'h1) begin
                        op_q <= ssf_pkg::SSF_IDLE;
                        status_q.busy <= 1'b0;
                        status_q.write_enable_latch <= 1'b0;
                    end else begin
                        busy_cnt_q <= busy_cnt_q - 32'h1;
                    end
                end
                ssf_pkg::SSF_SLEEP: begin
                    // Everything but the release opcode is ignored asleep
                    if (cs_rise && opcode_q == `SSF_OP_RES && byte_cnt_q != 3'h0) begin
                        op_q <= ssf_pkg::SSF_IDLE;
                    end
                end
                default: begin
                    op_q <= ssf_pkg::SSF_IDLE;
                end
            endcase
        end
    end

    assign o_flash_status = status_q;

    // Page buffer; bytes past the page end wrap within it
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            pmask_q <= '0;
            pg_ptr_q <= 8'h00;
        end else if (byte_done && opcode_q == `SSF_OP_PROG) begin
            if (byte_cnt_q == 3'h3) begin
                pg_ptr_q <= rx_byte;
                pmask_q <= '0;
            end else if (byte_cnt_q >= 3'h4) begin
                page_q[pg_ptr_q] <= rx_byte;
                pmask_q[pg_ptr_q] <= 1'b1;
                pg_ptr_q <= pg_ptr_q + 8'h01;
            end
        end
    end

    // Array: program only clears bits, erase sets whole bytes
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            for (int i = 0; i < STORE_BYTES; i++) begin
                mem_q[i] <= 8'hFF;
            end
        end else if (do_prog) begin
            for (int i = 0; i < `SSF_PAGE_SIZE; i++) begin
                if (pmask_q[i]) begin
                    mem_q[STORE_AW'({addr_q[23:8], 8'(i)})] <=
                        mem_q[STORE_AW'({addr_q[23:8], 8'(i)})] & page_q[i];
                end
            end
        end else if (do_serase || do_berase) begin
            for (int i = 0; i < STORE_BYTES; i++) begin
                if (do_berase || (((24'(i) ^ addr_q) & `SSF_SECTOR_MASK &
                    24'(STORE_BYTES - 1)) == 24'h0)) begin
                    mem_q[i] <= 8'hFF;
                end
            end
        end
    end

    // Checks
    property p_bp_lock;
        @(posedge i_clk) disable iff (i_srst)
        $changed(status_q.bp) |-> !$past(status_q.lock);
    endproperty
    a_bp_lock: assert property (p_bp_lock) else $error("protect bits changed while locked");
    property p_bp_src;
        @(posedge i_clk) disable iff (i_srst)
        $changed(status_q.bp) |-> $past(cs_rise) && $past(opcode_q) == `SSF_OP_WRSR;
    endproperty
    a_bp_src: assert property (p_bp_src) else $error("protect bits changed without write");
    property p_rsvd;
        @(posedge i_clk) disable iff (i_srst)
        byte_done && byte_cnt_q == 3'h0 && rx_byte == `SSF_OP_RDSR
        && op_q != ssf_pkg::SSF_SLEEP
        |=> tx_q[6:5] == 2'h0 && tx_q == $past(status_q);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("status byte wrong");
    property p_wel;
        @(posedge i_clk) disable iff (i_srst)
        $rose(status_q.write_enable_latch) |-> $past(cs_rise && opcode_q == `SSF_OP_WREN);
    endproperty
    a_wel: assert property (p_wel) else $error("latch set without enable");
    property p_busy;
        @(posedge i_clk) disable iff (i_srst)
        $rose(status_q.busy) |-> $past(status_q.write_enable_latch) && $past(cs_rise);
    endproperty
    a_busy: assert property (p_busy) else $error("busy without enabled write");
    property p_rdid;
        @(posedge i_clk) disable iff (i_srst)
        byte_done && byte_cnt_q == 3'h2 && opcode_q == `SSF_OP_RDID
        && op_q == ssf_pkg::SSF_IDLE |=> tx_q == CAP_ID && tx_en_q;
    endproperty
    a_rdid: assert property (p_rdid) else $error("third id byte wrong");
    property p_sig;
        @(posedge i_clk) disable iff (i_srst)
        byte_done && byte_cnt_q == 3'h0 && rx_byte == `SSF_OP_RES
        && (op_q == ssf_pkg::SSF_IDLE || op_q == ssf_pkg::SSF_SLEEP) |=> tx_q == SIGNATURE;
    endproperty
    a_sig: assert property (p_sig) else $error("signature missing");
    property p_sleep;
        @(posedge i_clk) disable iff (i_srst)
        accept && opcode_q == `SSF_OP_DPD && byte_cnt_q == 3'h1
        |=> op_q == ssf_pkg::SSF_SLEEP ##1 op_q == ssf_pkg::SSF_SLEEP;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep not entered");
    property p_range;
        @(posedge i_clk) disable iff (i_srst)
        accept && opcode_q == `SSF_OP_PROG && addr_q >= `SSF_MEM_SIZE |=> !status_q.busy;
    endproperty
    a_range: assert property (p_range) else $error("out of range program ran");
    property p_opcode;
        @(posedge i_clk) disable iff (i_srst)
        byte_done && byte_cnt_q == 3'h0 |=> opcode_q == $past(rx_byte);
    endproperty
    a_opcode: assert property (p_opcode) else $error("opcode not captured");
    c_prog: cover property (@(posedge i_clk) disable iff (i_srst) do_prog);
    c_berase: cover property (@(posedge i_clk) disable iff (i_srst) do_berase);
    c_read: cover property (@(posedge i_clk) disable iff (i_srst) rd_take && byte_done);
endmodule

// file: design/ssf_regs.svh
// Constants of the serial flash command sequencer: opcodes, status layout,
// sizes and default busy times. Included by the device and the bench.
`ifndef SSF_REGS_SVH
`define SSF_REGS_SVH
// Opcodes
`define SSF_OP_WREN 8'h06
`define SSF_OP_WRDI 8'h04
`define SSF_OP_RDSR 8'h05
`define SSF_OP_WRSR 8'h01
`define SSF_OP_READ 8'h03
`define SSF_OP_FAST 8'h0B
`define SSF_OP_PROG 8'h02
`define SSF_OP_SERASE 8'hD8
`define SSF_OP_BERASE 8'hC7
`define SSF_OP_DPD 8'hB9
`define SSF_OP_RES 8'hAB
`define SSF_OP_RDID 8'h9F
// Status register bit positions and reset value
`define SSF_ST_LOCK 7
`define SSF_ST_BP_HI 4
`define SSF_ST_BP_LO 2
`define SSF_ST_LATCH 1
`define SSF_ST_BUSY 0
`define SSF_ST_RESET 8'h00
// Frame, page and array sizes in bytes, and the sector mask
`define SSF_CMD_SIZE 3'h1
`define SSF_ADDR_SIZE 3'h3
`define SSF_PAGE_SIZE 256
`define SSF_MEM_SIZE 24'h200000
`define SSF_SECTOR_MASK 24'hFF0000
// Busy durations in system clock cycles
`define SSF_PROG_CYCLES 500
`define SSF_SERASE_CYCLES 2000
`define SSF_BERASE_CYCLES 4000
`endif

// file: design/ssf_pkg.sv
// Types shared by the serial flash device: status layout and busy state.
// Assumes ssf_regs.svh holds the bit positions these types mirror.
package ssf_pkg;
    // Status register, bit 7 down to bit 0
    typedef struct packed {
        logic lock;
        logic [1:0] rsvd;
        logic [2:0] bp;
        logic write_enable_latch;
        logic busy;
    } ssf_status_type;

    // Internal operation state, one-hot
    typedef enum logic [3:0] {
        SSF_IDLE = 4'b0001,
        SSF_PROG = 4'b0010,
        SSF_ERASE = 4'b0100,
        SSF_SLEEP = 4'b1000
    } ssf_op_type;
endpackage

// file: testbench/ssf_host_model.sv
// Host side of the serial flash link: select, serial clock and data out.
// Assumes the bench resolves the flash data line and feeds it as i_miso.
`timescale 1ns/10ps
module ssf_host_model (
    input wire logic i_clk,
    input wire logic i_miso,
    input wire logic i_miso_oe,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_mosi
);
    logic oe_seen;

    // Idle pins: select released, clock and data out high
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b1;
        o_mosi = 1'b1;
        oe_seen = 1'b0;
    end

    // One bit, 160 ns period: data set on clock fall, reply taken on rise
    task automatic bit_x(input logic tx, output logic rx);
        @(negedge i_clk);
        o_sclk = 1'b0;
        o_mosi = tx;
        repeat (8) @(negedge i_clk);
        o_sclk = 1'b1;
        rx = i_miso;
        oe_seen = oe_seen | i_miso_oe;
        repeat (7) @(negedge i_clk);
    endtask

    // Opcode and header bytes MSB first, then nr reply bytes captured
    task automatic frame(input logic [63:0] hdr, input int nh, input int nr,
                         output logic [23:0] rx);
        logic b;
        rx = 24'h000000;
        oe_seen = 1'b0;
        @(negedge i_clk);
        o_cs_n = 1'b0;
        repeat (8) @(negedge i_clk);
        for (int i = 0; i < nh * 8; i++) begin
            bit_x(hdr[63 - i], b);
        end
        // Access time before sampling; clock stands still meanwhile
        if (nr > 0) repeat (100) @(negedge i_clk);
        for (int i = 0; i < nr * 8; i++) begin
            bit_x(1'b0, b);
            rx = {rx[22:0], b};
        end
        @(negedge i_clk);
        o_mosi = 1'b1;
        repeat (8) @(negedge i_clk);
        o_cs_n = 1'b1;
        repeat (100) @(negedge i_clk);
    endtask
endmodule

// file: testbench/spi_serial_flash_command_sequencer_tb.sv
// Self-checking bench for the serial flash device through a host model.
// Assumes the package and the constants header are compiled first.
`timescale 1ns/10ps
`include "ssf_regs.svh"
module spi_serial_flash_command_sequencer_tb;
    localparam logic [7:0] MAKER = 8'h11; // Arbitrary value
    localparam logic [7:0] KIND = 8'h22; // Arbitrary value
    localparam logic [7:0] CAP = 8'h33; // Arbitrary value
    localparam logic [7:0] SIG = 8'h44; // Arbitrary value
    typedef struct packed {
        logic [63:0] hdr;
        logic [3:0] nh;
        logic [3:0] nr;
        logic [23:0] exp;
    } ssf_tb_row_type;
    // Plain frames: header, lengths, expected reply
    localparam ssf_tb_row_type ROWS [5] = '{
        '{{`SSF_OP_RDSR, 56'h0}, 4'h1, 4'h1, 24'h000000},
        '{{`SSF_OP_RES, 56'h0}, 4'h1, 4'h1, {16'h0, SIG}},
        '{{`SSF_OP_RDID, 56'h0}, 4'h1, 4'h3, {MAKER, KIND, CAP}},
        '{{`SSF_OP_READ, 24'h000010, 32'h0}, 4'h4, 4'h2, 24'h00FFFF},
        '{{`SSF_OP_FAST, 24'h1FFFFF, 32'h0}, 4'h5, 4'h1, 24'h0000FF}
    };
    logic i_clk;
    logic i_srst;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic din;
    logic din_oe;
    logic fill_q = 1'b0;
    logic [23:0] rx;
    ssf_pkg::ssf_status_type status;
    int n_errors = 0;
    int check_count = 0;

    // Released line shows a changing pattern, never the last bit
    always_ff @(posedge i_clk) fill_q <= ~fill_q;

    ssf_flash_device #(
        .PROG_CYCLES(200),
        .SERASE_CYCLES(200),
        .BERASE_CYCLES(200),
        .MAKER_ID(MAKER),
        .TYPE_ID(KIND),
        .CAP_ID(CAP),
        .SIGNATURE(SIG)
    ) uut (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_cs_n(cs_n),
        .i_sclk(sclk),
        .i_host_data_output(mosi),
        .o_host_data_input(din),
        .o_host_data_input_oe(din_oe),
        .o_flash_status(status)
    );

    ssf_host_model host (
        .i_clk(i_clk),
        .i_miso(din_oe ? din : fill_q),
        .i_miso_oe(din_oe),
        .o_cs_n(cs_n),
        .o_sclk(sclk),
        .o_mosi(mosi)
    );

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmd(input logic [63:0] hdr, input int nh, input int nr);
        host.frame(hdr, nh, nr, rx);
    endtask

    task automatic rdsr();
        cmd({`SSF_OP_RDSR, 56'h0}, 1, 1);
    endtask

    task automatic wren();
        cmd({`SSF_OP_WREN, 56'h0}, 1, 0);
    endtask

    // Poll busy with a bounded count; running out ends the run
    task automatic wait_idle();
        int n;
        n = 0;
        rdsr();
        while (rx[0] !== 1'b0 && n < 40) begin
            n++;
            rdsr();
        end
        if (rx[0] !== 1'b0) begin
            n_errors++;
            $display("[FAIL] busy poll expected 0 seen 1");
            report_and_stop();
        end
    endtask

    initial begin
        i_srst = 1'b1;
        repeat (10) @(negedge i_clk);
        i_srst = 1'b0;
        check("status after reset", {16'h0, status}, 24'h0);
        check("oe after reset", {23'h0, din_oe}, 24'h0);
        repeat (3) @(negedge i_clk);
        foreach (ROWS[k]) begin
            cmd(ROWS[k].hdr, int'(ROWS[k].nh), int'(ROWS[k].nr));
            check("row reply", rx, ROWS[k].exp);
        end
        $display("table cases done");
        // Beyond the array: aliased byte 0 must stay erased
        wren();
        cmd({`SSF_OP_PROG, 24'h200000, 8'h5A, 24'h0}, 5, 0);
        cmd({`SSF_OP_READ, 24'h000000, 32'h0}, 4, 1);
        check("range refuse", rx, 24'h0000FF);
        // Two bytes across a page end wrap to its start
        wren();
        rdsr();
        check("latch set", rx, 24'h000002);
        cmd({`SSF_OP_PROG, 24'h0000FF, 16'hABCD, 16'h0}, 6, 0);
        check("busy", {23'h0, status.busy}, 24'h000001);
        wait_idle();
        check("latch after program", rx, 24'h0);
        cmd({`SSF_OP_READ, 24'h0000FF, 32'h0}, 4, 2);
        check("page end", rx, 24'h00ABFF);
        cmd({`SSF_OP_READ, 24'h000000, 32'h0}, 4, 1);
        check("page wrap", rx, 24'h0000CD);
        cmd({`SSF_OP_PROG, 24'h000010, 8'h77, 24'h0}, 5, 0);
        cmd({`SSF_OP_READ, 24'h000010, 32'h0}, 4, 1);
        check("no wel refuse", rx, 24'h0000FF);
        $display("program cases done");
        // Protection, lock, reserved bits, bulk erase refused
        wren();
        cmd({`SSF_OP_WRSR, 8'h1C, 48'h0}, 2, 0);
        rdsr();
        check("protect all", rx, 24'h00001C);
        wren();
        cmd({`SSF_OP_BERASE, 56'h0}, 1, 0);
        wren();
        cmd({`SSF_OP_WRSR, 8'hFC, 48'h0}, 2, 0);
        rdsr();
        check("lock set", rx, 24'h00009C);
        wren();
        cmd({`SSF_OP_WRSR, 8'h00, 48'h0}, 2, 0);
        rdsr();
        check("bp held by lock", rx, 24'h00001C);
        wren();
        cmd({`SSF_OP_WRSR, 8'h00, 48'h0}, 2, 0);
        rdsr();
        check("protect cleared", rx, 24'h0);
        cmd({`SSF_OP_READ, 24'h0000FF, 32'h0}, 4, 1);
        check("bulk refused", rx, 24'h0000AB);
        // Sector erase at the masked base address
        wren();
        cmd({`SSF_OP_SERASE, 24'h0000FF & `SSF_SECTOR_MASK, 32'h0}, 4, 0);
        wait_idle();
        cmd({`SSF_OP_READ, 24'h0000FF, 32'h0}, 4, 1);
        check("sector erased", rx, 24'h0000FF);
        $display("protect and erase cases done");
        // Sleep ignores status reads; wake returns the signature
        cmd({`SSF_OP_DPD, 56'h0}, 1, 0);
        repeat (400) @(negedge i_clk);
        rdsr();
        check("asleep silent", {23'h0, host.oe_seen}, 24'h0);
        cmd({`SSF_OP_RES, 56'h0}, 1, 1);
        check("signature", rx, {16'h0, SIG});
        repeat (3000) @(negedge i_clk);
        rdsr();
        check("awake", {23'h0, host.oe_seen}, 24'h000001);
        // Write disable drops the latch
        wren();
        cmd({`SSF_OP_WRDI, 56'h0}, 1, 0);
        rdsr();
        check("latch dropped", rx, 24'h0);
        // Reset in mid-run drops the latch
        wren();
        check("latch before reset", {16'h0, status}, 24'h000002);
        i_srst = 1'b1;
        repeat (10) @(negedge i_clk);
        i_srst = 1'b0;
        check("status after rereset", {16'h0, status}, 24'h0);
        repeat (3) @(negedge i_clk);
        rdsr();
        check("read after rereset", rx, 24'h0);
        $display("power and reset cases done");
        report_and_stop();
    end
endmodule
